// ---- pmt_defs.vh ----
// Constants for the period match timer: register offsets, field positions,
// reset values and the instruction clock divider.
// Assumes inclusion by bare name from the timer design file.
`ifndef PMT_DEFS_VH
`define PMT_DEFS_VH

`define PMT_OFF_COUNT 4'h0
`define PMT_OFF_PERIOD 4'h4
`define PMT_OFF_CONTROL 4'h8
`define PMT_OFF_IRQ 4'hc

`define PMT_CTL_PRE_LO 0
`define PMT_CTL_PRE_HI 1
`define PMT_CTL_ON 2
`define PMT_CTL_POST_LO 3
`define PMT_CTL_POST_HI 6
`define PMT_IRQ_FLAG 0
`define PMT_IRQ_EN 1

`define PMT_COUNT_RST 8'h00
`define PMT_PERIOD_RST 8'hff
`define PMT_CONTROL_RST 7'h00
`define PMT_INSTR_DIV 2'h3
`define PMT_PRE4_LAST 2'h3
`define PMT_PRE16_LAST 4'hf

`define PMT_RESP_OKAY 2'h0
`define PMT_RESP_SLVERR 2'h2

`endif

// ---- pmt_timer.v ----
// Eight-bit period match timer with prescaler, postscaler and match flag,
// reached over an AXI4-Lite slave.
// Assumes one clock core_clk and a synchronous active-high reset.
//
// Functional notes
// - Eight-bit timer count register and eight-bit period register are provided.
// - Count and period are directly readable and writable, unbuffered.
// - Prescaler offers direct, divide by 4 and divide by 16 ratios.
// - Postscaler divides match events by any ratio from 1 to 16.
// - When enabled, count increments from zero per prescaled instruction tick.
// - Count is compared to period every cycle; equality gives match pulse.
// - Match clears the count next tick and advances the postscaler.
// - Postscaled matches can raise an interrupt.
// - Control bit 2 enables counting; clear stops the timer.
// - Reset clears count and sets period to all ones.
// - Count write, control write and reset clear both scaler counters.
// - Writing control leaves the count value unchanged.
// - Unscaled match is offered as shift clock for the serial port.
// - Postscale field value n selects a ratio of n plus one.
// - Postscaler output sets a latched flag; request needs the enable bit.
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pmt_defs.vh"

module pmt_timer (
  input wire core_clk,
  input wire reset,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg match_pulse,
  output reg shift_clk_tick,
  output reg match_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Word index of a byte offset; the low two address bits never select.
  function [1:0] pmt_word;
    input [3:0] byte_off;
    begin
      pmt_word = byte_off[3:2];
    end
  endfunction

  // True on the last instruction tick of the selected prescale ratio.
  function pmt_pre_last;
    input [1:0] sel;
    input [3:0] cnt;
    begin
      if (sel[1]) begin
        pmt_pre_last = (cnt == `PMT_PRE16_LAST);
      end else if (sel[0]) begin
        pmt_pre_last = (cnt[1:0] == `PMT_PRE4_LAST);
      end else begin
        pmt_pre_last = 1'b1;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: address and data latched independently, answered together.

  reg aw_held_r;
  reg w_held_r;
  reg [3:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg [7:0] timer_count_r;
  reg [7:0] period_value_r;
  reg [6:0] timer_control_r;
  reg match_irq_flag_r;
  reg match_irq_enable_r;
  reg [1:0] instr_div_r;
  reg [3:0] pre_cnt_r;
  reg [3:0] post_cnt_r;

  wire wr_fire;
  wire wr_lane0;
  wire wr_count;
  wire wr_period;
  wire wr_control;
  wire wr_irq;

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_lane0 = wr_fire && w_strb_r[0];
  assign wr_count = wr_lane0 && (aw_addr_r[3:2] == pmt_word(`PMT_OFF_COUNT));
  assign wr_period = wr_lane0 && (aw_addr_r[3:2] == pmt_word(`PMT_OFF_PERIOD));
  assign wr_control = wr_lane0 && (aw_addr_r[3:2] == pmt_word(`PMT_OFF_CONTROL));
  assign wr_irq = wr_lane0 && (aw_addr_r[3:2] == pmt_word(`PMT_OFF_IRQ));

  always @(posedge core_clk) begin
    if (reset) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PMT_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `PMT_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // All four words of the 16-byte window are mapped, so reads answer OKAY.
  always @(posedge core_clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PMT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `PMT_RESP_OKAY;
      case (s_axi_araddr[3:2])
        pmt_word(`PMT_OFF_COUNT): s_axi_rdata <= {24'h000000, timer_count_r};
        pmt_word(`PMT_OFF_PERIOD): s_axi_rdata <= {24'h000000, period_value_r};
        pmt_word(`PMT_OFF_CONTROL): s_axi_rdata <= {25'h0, timer_control_r};
        default: s_axi_rdata <= {30'h00000000, match_irq_enable_r, match_irq_flag_r};
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer core.

  wire timer_on;
  wire [1:0] prescale_select;
  wire [3:0] postscale_select;
  wire instr_tick;
  wire pre_tick;
  wire count_match;
  wire post_wrap;
  wire scaler_clear;
  wire match_event;
  wire flag_event;
  reg [3:0] pre_cnt_nxt;
  reg [7:0] timer_count_nxt;
  reg [3:0] post_cnt_nxt;
  reg match_irq_flag_nxt;

  assign timer_on = timer_control_r[`PMT_CTL_ON];
  assign prescale_select = timer_control_r[`PMT_CTL_PRE_HI:`PMT_CTL_PRE_LO];
  assign postscale_select = timer_control_r[`PMT_CTL_POST_HI:`PMT_CTL_POST_LO];
  assign scaler_clear = wr_count || wr_control;

  // The instruction clock is core_clk divided by four.
  assign instr_tick = (instr_div_r == `PMT_INSTR_DIV);

  // Prescaled tick: the last count of the selected ratio.
  assign pre_tick = instr_tick && timer_on && pmt_pre_last(prescale_select, pre_cnt_r);

  // Compared on every clock; the match acts at the next prescaled tick.
  assign count_match = (timer_count_r == period_value_r);
  assign post_wrap = (post_cnt_r == postscale_select);
  assign match_event = pre_tick && count_match;
  // A count or control write clears the postscaler on the same edge, so the
  // match that coincides with it must not set the flag as well.
  assign flag_event = match_event && post_wrap && !scaler_clear;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction clock divider and prescaler.

  always @* begin
    pre_cnt_nxt = pre_cnt_r;
    if (scaler_clear) begin
      pre_cnt_nxt = 4'h0;
    end else if (pre_tick) begin
      pre_cnt_nxt = 4'h0;
    end else if (instr_tick && timer_on) begin
      pre_cnt_nxt = pre_cnt_r + 4'h1;
    end
  end

  // The divider runs free, so software writes never shift the tick phase.
  always @(posedge core_clk) begin
    if (reset) begin
      instr_div_r <= 2'h0;
      pre_cnt_r <= 4'h0;
    end else begin
      instr_div_r <= instr_div_r + 2'h1;
      pre_cnt_r <= pre_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer count and postscaler.

  always @* begin
    timer_count_nxt = timer_count_r;
    if (match_event) begin
      timer_count_nxt = 8'h00;
    end else if (pre_tick) begin
      timer_count_nxt = timer_count_r + 8'h01;
    end
    if (wr_count) begin
      timer_count_nxt = w_data_r[7:0];
    end
  end

  always @* begin
    post_cnt_nxt = post_cnt_r;
    if (scaler_clear) begin
      post_cnt_nxt = 4'h0;
    end else if (match_event) begin
      post_cnt_nxt = post_wrap ? 4'h0 : post_cnt_r + 4'h1;
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      timer_count_r <= `PMT_COUNT_RST;
      post_cnt_r <= 4'h0;
    end else begin
      timer_count_r <= timer_count_nxt;
      post_cnt_r <= post_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written settings.

  always @(posedge core_clk) begin
    if (reset) begin
      period_value_r <= `PMT_PERIOD_RST;
      timer_control_r <= `PMT_CONTROL_RST;
      match_irq_enable_r <= 1'b0;
    end else begin
      if (wr_period) begin
        period_value_r <= w_data_r[7:0];
      end
      if (wr_control) begin
        timer_control_r <= w_data_r[6:0];
      end
      if (wr_irq) begin
        match_irq_enable_r <= w_data_r[`PMT_IRQ_EN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Match flag and outputs.

  // Software may only clear the flag; a coincident hardware set wins.
  always @* begin
    match_irq_flag_nxt = match_irq_flag_r;
    if (wr_irq && !w_data_r[`PMT_IRQ_FLAG]) begin
      match_irq_flag_nxt = 1'b0;
    end
    if (flag_event) begin
      match_irq_flag_nxt = 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      match_irq_flag_r <= 1'b0;
      match_pulse <= 1'b0;
      shift_clk_tick <= 1'b0;
      match_irq <= 1'b0;
    end else begin
      match_irq_flag_r <= match_irq_flag_nxt;
      match_pulse <= match_event;
      shift_clk_tick <= match_event;
      match_irq <= match_irq_flag_r && match_irq_enable_r;
    end
  end

endmodule // pmt_timer

`default_nettype wire

// ---- pmt_timer_properties.sv ----
// Checker for the period match timer, watching the top module's ports only.
// Assumes core_clk and a synchronous active-high reset; bound after the module.
`timescale 1ns/1ps
`default_nettype none
module pmt_props (
  input wire core_clk,
  input wire reset,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire match_pulse,
  input wire shift_clk_tick
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  a_match_twin: assert property (match_pulse == shift_clk_tick)
    else $error("shift tick differs from match pulse");
  // Ticks come every fourth clock at best, so two matches are never closer.
  a_pulse_gap: assert property (match_pulse |=> !match_pulse [*3])
    else $error("match pulses too close");
  // Both halves are held for one cycle before the write lands and is answered.
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write not answered");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && s_axi_rresp == 2'h0)
    else $error("read not answered");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_b_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("write response not okay");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
endmodule // pmt_props
bind pmt_timer pmt_props pmt_props_i (.*);
`default_nettype wire

// ---- pmt_timer_bench.sv ----
// Self-checking bench for the period match timer over AXI4-Lite.
// Assumes an 8 ns clock; the timer is driven only through its registers.
`timescale 1ns/1ps
`default_nettype none
module pmt_timer_bench;
  logic core_clk = 0, reset = 1;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire match_pulse, shift_clk_tick, match_irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int err_total = 0, samples_checked = 0, n, k;
  int dv[4] = '{1, 4, 16, 16};
  pmt_timer pmt_timer_i (.*);
  initial forever #4 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Readies are sampled at the falling edge, where they are settled.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(ad && wd)) begin
      @(negedge core_clk);
      ad = ad | (s_axi_awready === 1'h1);
      wd = wd | (s_axi_wready === 1'h1);
      @(posedge core_clk);
      if (ad) s_axi_awvalid <= 1'h0;
      if (wd) s_axi_wvalid <= 1'h0;
    end
    @(negedge core_clk);
    while (s_axi_bvalid !== 1'h1) @(negedge core_clk);
    @(posedge core_clk);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    @(negedge core_clk);
    while (s_axi_arready !== 1'h1) @(negedge core_clk);
    @(posedge core_clk);
    s_axi_arvalid <= 1'h0;
    @(negedge core_clk);
    while (s_axi_rvalid !== 1'h1) @(negedge core_clk);
    q = s_axi_rdata;
    @(posedge core_clk);
    s_axi_rready <= 1'h0;
    chk("rdata", q, exp);
  endtask
  task automatic gap(output int c);
    c = 0;
    do begin
      @(negedge core_clk);
      c++;
    end while (match_pulse !== 1'h1 && c < 2000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'h0;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'hff);
    rd(4'h8, 32'h0);
    rd(4'hc, 32'h0);
    wr(4'h4, 32'h15a);
    rd(4'h4, 32'h5a);
    wr(4'h0, 32'h33);
    wr(4'h8, 32'h8b);
    rd(4'h8, 32'h0b);
    rd(4'h0, 32'h33);
    wr(4'h4, 32'h3);
    wr(4'h0, 32'h0);
    // Period 3 gives four ticks per match, so the gap is 16 clocks per ratio step.
    for (int c = 0; c < 4; c++) begin
      wr(4'h8, 32'h4 + 32'(c));
      gap(n);
      gap(n);
      chk("gap", 32'(n), 32'(16 * dv[c]));
    end
    wr(4'h4, 32'h1);
    for (int p = 0; p < 16; p++) begin
      wr(4'h8, 32'h0);
      wr(4'h0, 32'h0);
      wr(4'hc, 32'h2);
      wr(4'h8, 32'h4 + 32'(p << 3));
      k = 0;
      do begin
        @(negedge core_clk);
        if (match_pulse === 1'h1) k++;
      end while (match_irq !== 1'h1 && k < 20);
      chk("matches", 32'(k), 32'(p + 1));
    end
    wr(4'h8, 32'h4);
    wr(4'hc, 32'h0);
    gap(n);
    gap(n);
    chk("irq", {31'h0, match_irq}, 32'h0);
    rd(4'hc, 32'h1);
    give_verdict;
  end
  initial begin
    #200000;
    err_total++;
    give_verdict;
  end
endmodule // pmt_timer_bench
`default_nettype wire
